//--- src/rfdp_pkg.sv
// Purpose: shared constants and types for the serial data pin and receiver control block
// Assumes: byte wide configuration registers reached over the two-wire slave port
// Notes:   every offset, bit position and reset value used by the design lives here
package rfdp_pkg;

	// ----------------------------------------------------------------
	// register indices and offsets
	// ----------------------------------------------------------------
	localparam int REG_COUNT = 10;
	localparam int IDX_ANT1 = 0;
	localparam int IDX_ANT2 = 1;
	localparam int IDX_SUPPLY = 2;
	localparam int IDX_XTAL = 3;
	localparam int IDX_SLICER = 4;
	localparam int IDX_PORTS = 5;
	localparam int IDX_ROUTING = 6;
	localparam int IDX_FILTER = 7;
	localparam int IDX_POLARITY = 8;
	localparam int IDX_PIN_MODE = 9;

	// antenna_one_tune, antenna_two_tune, amplifier_supply_trim, receive_crystal_tune,
	// slicer_reference, port_enables, pin_routing_control, filter_select,
	// polarity_control, data_pin_mode
	localparam logic [7:0] REG_OFS [REG_COUNT] = '{
		8'h00, 8'h01, 8'h02, 8'h05, 8'h0a, 8'h0c, 8'h0e, 8'h0f, 8'h1e, 8'h1d
	};
	localparam logic [7:0] REG_RST [REG_COUNT] = '{
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00
	};
	localparam logic [7:0] UNMAPPED_READ = 8'h00;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int ANT1_ON_BIT = 0;
	localparam int ANT2_ON_BIT = 1;
	localparam int NO_INC_BIT = 2;
	localparam int RX_ON_BIT = 3;
	localparam int TX_ON_BIT = 4;
	localparam int OSC_SEL_BIT = 2;
	localparam int INVERT_BIT = 5;
	localparam int FILTER_LSB = 4;
	localparam int FILTER_MSB = 6;
	localparam int CDR_SEL_BIT = 0;
	localparam int ENERGY_LOW_BIT = 1;

	// bus address, write form; the read form sets bit 0
	localparam logic [7:0] DEV_ADDR_WR = 8'h68;
	localparam logic [2:0] LAST_BIT = 3'h7;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		ST_IDLE, ST_DEVADDR, ST_ADDR_ACK, ST_PTR, ST_PTR_ACK,
		ST_WRITE, ST_WRITE_ACK, ST_READ, ST_READ_ACK, ST_READ_LOAD
	} rfdp_state_type;

	typedef enum logic [2:0] {
		ROLE_OFF, ROLE_TX_IN, ROLE_RX_OUT, ROLE_OSC_OUT, ROLE_CDR_OUT
	} rfdp_role_type;

	typedef struct packed {
		logic [7:0] antenna_one_tune;
		logic [7:0] antenna_two_tune;
		logic [7:0] amplifier_supply_output;
		logic [7:0] receive_crystal_tune;
		logic [2:0] filter_code;
		logic antenna_one_port_on;
		logic antenna_two_port_on;
		logic receiver_on;
	} rfdp_cfg_type;

endpackage : rfdp_pkg

//--- src/rfdp_reg_byte.sv
// Purpose: one byte of configuration storage
// Assumes: write enable is a one-cycle pulse already decoded for this byte
// Notes:   reset value comes in as a parameter
`timescale 1ns/10ps
module rfdp_reg_byte #(
	parameter logic [7:0] RST = 8'h00
) (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// write port
	input wire logic wr_en,
	input wire logic [7:0] wr_data,
	// stored value
	output logic [7:0] q
);

	// hold until written
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			q <= RST;
		end else if (wr_en) begin
			q <= wr_data;
		end
	end

endmodule : rfdp_reg_byte

//--- src/rfdp_pin_edge.sv
// Purpose: registered copy of a pin with rise and fall pulses
// Assumes: pin is synchronous to clk
// Notes:   one cycle of delay from pin to level
`timescale 1ns/10ps
module rfdp_pin_edge (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// pin
	input wire logic pin,
	// results
	output logic level,
	output logic rise,
	output logic fall
);

	logic prev_q;

	// idle level of the bus lines is high
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			level <= 1'b1;
			prev_q <= 1'b1;
		end else begin
			level <= pin;
			prev_q <= level;
		end
	end

	assign rise = level & ~prev_q;
	assign fall = ~level & prev_q;

endmodule : rfdp_pin_edge

//--- src/rfdp_top.sv
// Purpose: serial data pin routing, receiver settings and two-wire register access
// Assumes: all pins synchronous to clk; bus clock far slower than clk
// Notes:   data pin and bus data line are open as three signals each
`timescale 1ns/10ps

// How it works
// - configuration picks pin role: transmit input, receive output, oscillator or recovered data
// - in transmit the pin level switches the power amplifier directly
// - transmit bits reach the amplifier unchanged, no framing or coding
// - invert bit 5 of 0x1e flips pin sense and amplifier control
// - in receive the detected data drives the pin as plain bits
// - a setting chooses whether energy shows high or low
// - bit 2 of 0x0e puts the low power oscillator on the pin
// - byte 0x02 sets amplifier supply, 0xff highest
// - bytes 0x00 and 0x01 are the two antenna trims
// - byte 0x0a is the slicing reference for each data bit
// - both channels summed; 0x0c bits 0,1,3 enable ports and receiver
// - bits 4 to 6 of 0x0f choose the data filter bandwidth
// - byte 0x05 tunes the receive crystal
// - bytes are read and written over the two-wire bus as slave
module rfdp_top (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// two-wire bus
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	// serial data pin
	input wire logic data_pin_in,
	output logic data_pin_out,
	output logic data_pin_oe,
	// analog side inputs
	input wire logic [7:0] ch1_level,
	input wire logic [7:0] ch2_level,
	input wire logic cdr_data,
	input wire logic osc_level,
	// analog side controls
	output logic pa_on,
	output rfdp_pkg::rfdp_cfg_type cfg,
	output rfdp_pkg::rfdp_role_type pin_role
);

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	logic [7:0] reg_q [rfdp_pkg::REG_COUNT];
	logic scl_q, scl_rise, scl_fall, sda_q, sda_rise, sda_fall, bus_start, bus_stop;
	rfdp_pkg::rfdp_state_type st_q;
	logic [7:0] sh_q, ptr_q, wr_addr_q, wr_data_q, rd_byte, in_byte;
	logic [2:0] cnt_q, filter_field;
	logic ackph_q, rw_q, sda_oe_q, wr_stb_q, no_inc;
	logic tx_on, rx_on, osc_sel, cdr_sel, inv_bit, energy_low;
	logic [8:0] chan_sum;
	logic rx_bit, pa_on_q, pin_out_q, pin_oe_q;
	rfdp_pkg::rfdp_cfg_type cfg_q;
	rfdp_pkg::rfdp_role_type role_q;

	// ----------------------------------------------------------------
	// register storage
	// ----------------------------------------------------------------
	// one cell per byte, decoded against its own offset
	for (genvar i = 0; i < rfdp_pkg::REG_COUNT; i++) begin : g_reg
		rfdp_reg_byte #(
			.RST(rfdp_pkg::REG_RST[i])
		) u_byte (
			.clk(clk),
			.sys_rst(sys_rst),
			.wr_en(wr_stb_q && (wr_addr_q == rfdp_pkg::REG_OFS[i])),
			.wr_data(wr_data_q),
			.q(reg_q[i])
		);
	end

	// read back; unmapped offsets return zero
	always_comb begin
		rd_byte = rfdp_pkg::UNMAPPED_READ;
		for (int i = 0; i < rfdp_pkg::REG_COUNT; i++) begin
			if (ptr_q == rfdp_pkg::REG_OFS[i]) begin
				rd_byte = reg_q[i];
			end
		end
	end

	// ----------------------------------------------------------------
	// two-wire slave
	// ----------------------------------------------------------------
	rfdp_pin_edge u_scl (.clk(clk), .sys_rst(sys_rst), .pin(scl_in),
		.level(scl_q), .rise(scl_rise), .fall(scl_fall));
	rfdp_pin_edge u_sda (.clk(clk), .sys_rst(sys_rst), .pin(sda_in),
		.level(sda_q), .rise(sda_rise), .fall(sda_fall));

	// data changes with clock high mark frame boundaries
	assign bus_start = scl_q & sda_fall;
	assign bus_stop = scl_q & sda_rise;
	assign in_byte = {sh_q[6:0], sda_q};
	assign no_inc = reg_q[rfdp_pkg::IDX_PORTS][rfdp_pkg::NO_INC_BIT];

	// byte engine; ack driven from the falling edge so setup is a full half period
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_q <= rfdp_pkg::ST_IDLE;
			sh_q <= 8'h00;
			cnt_q <= 3'h0;
			ackph_q <= 1'b0;
			rw_q <= 1'b0;
			ptr_q <= 8'h00;
			sda_oe_q <= 1'b0;
			wr_stb_q <= 1'b0;
			wr_addr_q <= 8'h00;
			wr_data_q <= 8'h00;
		end else begin
			wr_stb_q <= 1'b0;
			if (bus_start) begin
				st_q <= rfdp_pkg::ST_DEVADDR;
				cnt_q <= 3'h0;
				ackph_q <= 1'b0;
				sda_oe_q <= 1'b0;
			end else if (bus_stop) begin
				st_q <= rfdp_pkg::ST_IDLE;
				sda_oe_q <= 1'b0;
			end else begin
				case (st_q)
					rfdp_pkg::ST_DEVADDR, rfdp_pkg::ST_PTR, rfdp_pkg::ST_WRITE: begin
						if (scl_rise) begin
							sh_q <= in_byte;
							cnt_q <= cnt_q + 3'h1;
							if (cnt_q == rfdp_pkg::LAST_BIT) begin
								if (st_q == rfdp_pkg::ST_DEVADDR) begin
									// only our address is answered
									if (sh_q[6:0] == rfdp_pkg::DEV_ADDR_WR[7:1]) begin
										rw_q <= sda_q;
										st_q <= rfdp_pkg::ST_ADDR_ACK;
									end else begin
										st_q <= rfdp_pkg::ST_IDLE;
									end
								end else if (st_q == rfdp_pkg::ST_PTR) begin
									ptr_q <= in_byte;
									st_q <= rfdp_pkg::ST_PTR_ACK;
								end else begin
									wr_stb_q <= 1'b1;
									wr_addr_q <= ptr_q;
									wr_data_q <= in_byte;
									st_q <= rfdp_pkg::ST_WRITE_ACK;
								end
							end
						end
					end
					rfdp_pkg::ST_ADDR_ACK, rfdp_pkg::ST_PTR_ACK, rfdp_pkg::ST_WRITE_ACK: begin
						if (scl_fall) begin
							if (!ackph_q) begin
								ackph_q <= 1'b1;
								sda_oe_q <= 1'b1;
							end else begin
								ackph_q <= 1'b0;
								sda_oe_q <= 1'b0;
								cnt_q <= 3'h0;
								if (st_q == rfdp_pkg::ST_ADDR_ACK && rw_q) begin
									// first read bit goes out on this same fall
									sh_q <= rd_byte;
									sda_oe_q <= ~rd_byte[7];
									st_q <= rfdp_pkg::ST_READ;
								end else if (st_q == rfdp_pkg::ST_ADDR_ACK) begin
									st_q <= rfdp_pkg::ST_PTR;
								end else begin
									if (st_q == rfdp_pkg::ST_WRITE_ACK && !no_inc) begin
										ptr_q <= ptr_q + 8'h01;
									end
									st_q <= rfdp_pkg::ST_WRITE;
								end
							end
						end
					end
					rfdp_pkg::ST_READ: begin
						if (scl_fall) begin
							if (cnt_q == rfdp_pkg::LAST_BIT) begin
								sda_oe_q <= 1'b0;
								st_q <= rfdp_pkg::ST_READ_ACK;
							end else begin
								sh_q <= {sh_q[6:0], 1'b0};
								sda_oe_q <= ~sh_q[6];
								cnt_q <= cnt_q + 3'h1;
							end
						end
					end
					rfdp_pkg::ST_READ_ACK: begin
						// master nack ends the read burst
						if (scl_rise) begin
							if (sda_q) begin
								st_q <= rfdp_pkg::ST_IDLE;
							end else begin
								ptr_q <= ptr_q + 8'h01;
								st_q <= rfdp_pkg::ST_READ_LOAD;
							end
						end
					end
					rfdp_pkg::ST_READ_LOAD: begin
						if (scl_fall) begin
							sh_q <= rd_byte;
							sda_oe_q <= ~rd_byte[7];
							cnt_q <= 3'h0;
							st_q <= rfdp_pkg::ST_READ;
						end
					end
					default: begin
						st_q <= rfdp_pkg::ST_IDLE;
					end
				endcase
			end
		end
	end

	// open drain: the line is only ever pulled low
	assign sda_out = 1'b0;
	assign sda_oe = sda_oe_q;

	// ----------------------------------------------------------------
	// receive slicer and pin routing
	// ----------------------------------------------------------------
	assign tx_on = reg_q[rfdp_pkg::IDX_PORTS][rfdp_pkg::TX_ON_BIT];
	assign rx_on = reg_q[rfdp_pkg::IDX_PORTS][rfdp_pkg::RX_ON_BIT];
	assign osc_sel = reg_q[rfdp_pkg::IDX_ROUTING][rfdp_pkg::OSC_SEL_BIT];
	assign cdr_sel = reg_q[rfdp_pkg::IDX_PIN_MODE][rfdp_pkg::CDR_SEL_BIT];
	assign energy_low = reg_q[rfdp_pkg::IDX_PIN_MODE][rfdp_pkg::ENERGY_LOW_BIT];
	assign inv_bit = reg_q[rfdp_pkg::IDX_POLARITY][rfdp_pkg::INVERT_BIT];
	assign filter_field = reg_q[rfdp_pkg::IDX_FILTER][rfdp_pkg::FILTER_MSB:rfdp_pkg::FILTER_LSB];

	// disabled ports contribute nothing; nine bits so the sum cannot wrap
	assign chan_sum = {1'b0, (reg_q[rfdp_pkg::IDX_PORTS][rfdp_pkg::ANT1_ON_BIT] ? ch1_level : 8'h00)}
		+ {1'b0, (reg_q[rfdp_pkg::IDX_PORTS][rfdp_pkg::ANT2_ON_BIT] ? ch2_level : 8'h00)};
	assign rx_bit = rx_on && (chan_sum > {1'b0, reg_q[rfdp_pkg::IDX_SLICER]});

	// oscillator wins over everything, then transmit, then recovered, then receive
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pa_on_q <= 1'b0;
			pin_out_q <= 1'b0;
			pin_oe_q <= 1'b0;
			role_q <= rfdp_pkg::ROLE_OFF;
		end else if (osc_sel) begin
			pa_on_q <= 1'b0;
			pin_out_q <= osc_level;
			pin_oe_q <= 1'b1;
			role_q <= rfdp_pkg::ROLE_OSC_OUT;
		end else if (tx_on) begin
			pa_on_q <= data_pin_in ^ inv_bit;
			pin_out_q <= 1'b0;
			pin_oe_q <= 1'b0;
			role_q <= rfdp_pkg::ROLE_TX_IN;
		end else if (cdr_sel) begin
			// recovered data is only meaningful once recovery mode is on
			pa_on_q <= 1'b0;
			pin_out_q <= cdr_data ^ inv_bit;
			pin_oe_q <= 1'b1;
			role_q <= rfdp_pkg::ROLE_CDR_OUT;
		end else if (rx_on) begin
			pa_on_q <= 1'b0;
			pin_out_q <= rx_bit ^ inv_bit ^ energy_low;
			pin_oe_q <= 1'b1;
			role_q <= rfdp_pkg::ROLE_RX_OUT;
		end else begin
			pa_on_q <= 1'b0;
			pin_out_q <= 1'b0;
			pin_oe_q <= 1'b0;
			role_q <= rfdp_pkg::ROLE_OFF;
		end
	end

	// ----------------------------------------------------------------
	// analog control copies
	// ----------------------------------------------------------------
	// registered so the analog side never sees a decode glitch
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cfg_q <= '0;
		end else begin
			cfg_q.antenna_one_tune <= reg_q[rfdp_pkg::IDX_ANT1];
			cfg_q.antenna_two_tune <= reg_q[rfdp_pkg::IDX_ANT2];
			cfg_q.amplifier_supply_output <= reg_q[rfdp_pkg::IDX_SUPPLY];
			cfg_q.receive_crystal_tune <= reg_q[rfdp_pkg::IDX_XTAL];
			cfg_q.filter_code <= filter_field;
			cfg_q.antenna_one_port_on <= reg_q[rfdp_pkg::IDX_PORTS][rfdp_pkg::ANT1_ON_BIT];
			cfg_q.antenna_two_port_on <= reg_q[rfdp_pkg::IDX_PORTS][rfdp_pkg::ANT2_ON_BIT];
			cfg_q.receiver_on <= rx_on;
		end
	end

	assign pa_on = pa_on_q;
	assign data_pin_out = pin_out_q;
	assign data_pin_oe = pin_oe_q;
	assign cfg = cfg_q;
	assign pin_role = role_q;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	pa_follow_a: assert property (@(posedge clk) disable iff (sys_rst)
		(tx_on && !osc_sel) |=> (pa_on == ($past(data_pin_in) ^ $past(inv_bit))))
		else $error("amplifier does not follow data pin");
	tx_release_a: assert property (@(posedge clk) disable iff (sys_rst)
		(tx_on && !osc_sel) |=> (!data_pin_oe && pin_role == rfdp_pkg::ROLE_TX_IN))
		else $error("data pin driven in transmit");
	osc_drive_a: assert property (@(posedge clk) disable iff (sys_rst)
		osc_sel |=> (data_pin_oe && !pa_on && data_pin_out == $past(osc_level)))
		else $error("oscillator not on data pin");
	rx_drive_a: assert property (@(posedge clk) disable iff (sys_rst)
		(rx_on && !tx_on && !osc_sel && !cdr_sel)
		|=> (data_pin_oe && data_pin_out == ($past(rx_bit) ^ $past(inv_bit) ^ $past(energy_low))))
		else $error("receive data wrong on pin");
	cdr_drive_a: assert property (@(posedge clk) disable iff (sys_rst)
		(cdr_sel && !tx_on && !osc_sel) |=> (data_pin_oe && data_pin_out == ($past(cdr_data) ^ $past(inv_bit))))
		else $error("recovered data wrong on pin");
	write_reach_a: assert property (@(posedge clk) disable iff (sys_rst)
		(wr_stb_q && wr_addr_q == rfdp_pkg::REG_OFS[rfdp_pkg::IDX_SUPPLY])
		|=> ##1 (cfg.amplifier_supply_output == $past(wr_data_q, 2)))
		else $error("supply write did not take effect");
	filter_map_a: assert property (@(posedge clk) disable iff (sys_rst)
		##1 (cfg.filter_code == $past(filter_field)))
		else $error("filter code mismatch");
	trim_map_a: assert property (@(posedge clk) disable iff (sys_rst)
		##1 (cfg.antenna_one_tune == $past(reg_q[rfdp_pkg::IDX_ANT1])
		&& cfg.receive_crystal_tune == $past(reg_q[rfdp_pkg::IDX_XTAL])))
		else $error("trim value mismatch");
	ack_drive_a: assert property (@(posedge clk) disable iff (sys_rst)
		(st_q == rfdp_pkg::ST_PTR_ACK && scl_fall && !ackph_q && !bus_start && !bus_stop) |=> sda_oe)
		else $error("pointer byte not acknowledged");

endmodule : rfdp_top

//--- tb/rfdp_host_model.sv
// Purpose: controller model: two-wire bus master and read result reporter
// Assumes: bus half period of six clk cycles, well above the slave's minimum
// Notes:   data line is open drain; a released line reads high through the wire pull-up
`timescale 1ns/10ps
module rfdp_host_model (
	// clock
	input wire logic clk,
	// two-wire bus
	input wire logic sda_wire,
	output logic scl,
	output logic sda_low,
	// results
	output logic rd_valid,
	output logic [7:0] rd_data,
	output logic last_ack
);
	// ----------------------------------------------------------------
	// bus primitives
	// ----------------------------------------------------------------
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
		rd_valid = 1'b0;
		rd_data = 8'h00;
		last_ack = 1'b0;
	end

	// every change lands just after a rising clk edge
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick

	// one bit slot; data moves a clk after scl falls, never while scl is high
	task automatic xfer_bit(input logic b, output logic s);
		sda_low = ~b;
		tick(5);
		scl = 1'b1;
		s = sda_wire;
		tick(6);
		scl = 1'b0;
		tick(1);
	endtask : xfer_bit

	// start and repeated start share one shape
	task automatic start;
		sda_low = 1'b0;
		tick(5);
		scl = 1'b1;
		tick(6);
		sda_low = 1'b1;
		tick(6);
		scl = 1'b0;
		tick(1);
	endtask : start

	task automatic stop;
		sda_low = 1'b1;
		tick(5);
		scl = 1'b1;
		tick(6);
		sda_low = 1'b0;
		tick(6);
	endtask : stop

	// msb first, then the slave's acknowledge slot
	task automatic send_byte(input logic [7:0] b);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			xfer_bit(b[i], s);
		end
		xfer_bit(1'b1, s);
		last_ack = ~s;
	endtask : send_byte

	task automatic recv_byte(input logic more);
		logic s;
		logic [7:0] d;
		for (int i = 7; i >= 0; i--) begin
			xfer_bit(1'b1, s);
			d[i] = s;
		end
		xfer_bit(~more, s);
		rd_data = d;
		rd_valid = 1'b1;
		tick(1);
		rd_valid = 1'b0;
	endtask : recv_byte

	// ----------------------------------------------------------------
	// register transfers
	// ----------------------------------------------------------------
	task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
		start();
		send_byte(rfdp_pkg::DEV_ADDR_WR);
		send_byte(a);
		send_byte(d);
		stop();
	endtask : write_reg

	// pointer write, repeated start, one byte ended by a nack
	task automatic read_reg(input logic [7:0] a);
		start();
		send_byte(rfdp_pkg::DEV_ADDR_WR);
		send_byte(a);
		start();
		send_byte(rfdp_pkg::DEV_ADDR_WR | 8'h01);
		recv_byte(1'b0);
		stop();
	endtask : read_reg
endmodule : rfdp_host_model

//--- tb/testbench.sv
// Purpose: self-checking bench for pin routing, receiver settings and register access
// Assumes: read results are checked against a queue of expected bytes
// Notes:   an undriven data pin toggles every cycle so stale values never match by luck
`timescale 1ns/10ps
module testbench;
	logic clk, sys_rst, scl, sda_low, rd_valid, last_ack, tx_en, tx_bit, idle_pat, cdr_data, osc_level;
	logic sda_out, sda_oe, data_pin_out, data_pin_oe, pa_on, inv, e;
	logic [7:0] rd_data, ch1, ch2, v, pe;
	logic [8:0] sum;
	rfdp_pkg::rfdp_cfg_type cfg;
	rfdp_pkg::rfdp_role_type pin_role;
	logic [7:0] exp_q[$];
	logic [7:0] ports_tab [3] = '{8'h09, 8'h0a, 8'h0b};
	int fail_count, checks, cycles, seed, m;
	wire sda_wire = ~((sda_oe & ~sda_out) | sda_low);
	wire pin_wire = data_pin_oe ? data_pin_out : (tx_en ? tx_bit : idle_pat);

	rfdp_top u_dut (.clk(clk), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_out),
		.sda_oe(sda_oe), .data_pin_in(pin_wire), .data_pin_out(data_pin_out), .data_pin_oe(data_pin_oe),
		.ch1_level(ch1), .ch2_level(ch2), .cdr_data(cdr_data), .osc_level(osc_level), .pa_on(pa_on),
		.cfg(cfg), .pin_role(pin_role));
	rfdp_host_model u_host (.clk(clk), .sda_wire(sda_wire), .scl(scl), .sda_low(sda_low),
		.rd_valid(rd_valid), .rd_data(rd_data), .last_ack(last_ack));

	// ----------------------------------------------------------------
	// clock, idle pattern, hang limit
	// ----------------------------------------------------------------
	always #10 clk = ~clk;
	always @(posedge clk) begin
		idle_pat <= ~idle_pat;
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			fail_count++;
			complete_run();
		end
	end

	// ----------------------------------------------------------------
	// compare tasks and closing report
	// ----------------------------------------------------------------
	task automatic check_bit(input logic got, input logic exp, input string what);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: %s got %b expected %b", $time, what, got, exp);
		end
	endtask : check_bit

	task automatic check_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : check_byte

	task automatic check_role(input rfdp_pkg::rfdp_role_type exp);
		checks++;
		if (pin_role !== exp) begin
			fail_count++;
			$display("unexpected at %0t: pin role %0d expected %0d", $time, pin_role, exp);
		end
	endtask : check_role

	task automatic complete_run;
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : complete_run

	// read data is paired with the oldest expectation
	always @(posedge clk) begin
		if (rd_valid === 1'b1) begin
			check_byte(rd_data, exp_q.pop_front(), "read");
		end
	end

	// ----------------------------------------------------------------
	// drivers
	// ----------------------------------------------------------------
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		u_host.write_reg(a, d);
		check_bit(last_ack, 1'b1, "data ack");
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] d);
		exp_q.push_back(d);
		u_host.read_reg(a);
	endtask : rd

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		sys_rst = 1'b1;
		{tx_en, tx_bit, idle_pat, cdr_data, osc_level, ch1, ch2} = '0;
		{fail_count, checks, cycles} = '0;
		seed = 13171;
		tick(12);
		sys_rst = 1'b0;
		tick(4);
		check_role(rfdp_pkg::ROLE_OFF);
		for (int i = 0; i < rfdp_pkg::REG_COUNT; i++) rd(rfdp_pkg::REG_OFS[i], rfdp_pkg::REG_RST[i]);
		// wrong device address is left unanswered
		u_host.start();
		u_host.send_byte(8'h6a);
		check_bit(last_ack, 1'b0, "foreign ack");
		u_host.stop();
		// trims reach their outputs at once and read back
		v = 8'($random(seed));
		wr(8'h00, v);
		check_byte(cfg.antenna_one_tune, v, "trim1");
		rd(8'h00, v);
		wr(8'h01, ~v);
		check_byte(cfg.antenna_two_tune, ~v, "trim2");
		rd(8'h01, ~v);
		wr(8'h02, 8'hff);
		check_byte(cfg.amplifier_supply_output, 8'hff, "supply");
		rd(8'h02, 8'hff);
		wr(8'h05, v);
		check_byte(cfg.receive_crystal_tune, v, "xtal");
		rd(8'h05, v);
		wr(8'h0a, 8'h80);
		rd(8'h0a, 8'h80);
		wr(8'h03, v);
		rd(8'h03, rfdp_pkg::UNMAPPED_READ);
		// two-byte write bursts: the pointer steps between bytes unless the hold bit is set
		for (m = 0; m < 2; m++) begin
			wr(8'h0c, {5'h00, m[0], 2'h0});
			u_host.start();
			u_host.send_byte(rfdp_pkg::DEV_ADDR_WR);
			u_host.send_byte(8'h00);
			u_host.send_byte(v ^ {8{m[0]}});
			u_host.send_byte(~v ^ {8{m[0]}});
			check_bit(last_ack, 1'b1, "burst ack");
			u_host.stop();
			rd(8'h00, v);
			rd(8'h01, ~v);
		end
		// read burst: a master ack moves on to the next byte
		exp_q.push_back(v);
		exp_q.push_back(~v);
		u_host.start();
		u_host.send_byte(rfdp_pkg::DEV_ADDR_WR);
		u_host.send_byte(8'h00);
		u_host.start();
		u_host.send_byte(rfdp_pkg::DEV_ADDR_WR | 8'h01);
		u_host.recv_byte(1'b1);
		u_host.recv_byte(1'b0);
		u_host.stop();
		for (int c = 0; c < 8; c++) begin
			wr(8'h0f, {1'b0, 3'(c), v[3:0]});
			check_byte({5'h00, cfg.filter_code}, 8'(c), "filter");
		end
		// transmit: pin level keys the amplifier, optionally inverted
		wr(8'h0c, 8'h10);
		tx_en = 1'b1;
		check_role(rfdp_pkg::ROLE_TX_IN);
		for (m = 0; m < 2; m++) begin
			inv = m[0];
			wr(8'h1e, inv ? 8'h20 : 8'h00);
			repeat (16) begin
				tx_bit = 1'($random(seed));
				tick(3);
				check_bit(pa_on, tx_bit ^ inv, "amplifier");
			end
		end
		check_bit(data_pin_oe, 1'b0, "pin released in transmit");
		// oscillator wins over transmit and ignores the invert bit
		wr(8'h0e, 8'h04);
		check_role(rfdp_pkg::ROLE_OSC_OUT);
		repeat (8) begin
			osc_level = 1'($random(seed));
			tick(3);
			check_bit(data_pin_out & data_pin_oe, osc_level, "oscillator");
		end
		wr(8'h0e, 8'h00);
		check_role(rfdp_pkg::ROLE_TX_IN);
		tx_en = 1'b0;
		// receive: summed enabled channels against the reference
		for (m = 0; m < 6; m++) begin
			pe = ports_tab[m % 3];
			e = (m >= 3);
			inv = (m == 5);
			wr(8'h0c, pe);
			wr(8'h1d, {6'h00, e, 1'b0});
			wr(8'h1e, inv ? 8'h20 : 8'h00);
			check_role(rfdp_pkg::ROLE_RX_OUT);
			check_bit(cfg.antenna_two_port_on, pe[1], "port two");
			check_bit(cfg.antenna_one_port_on, pe[0], "port one");
			check_bit(cfg.receiver_on, pe[3], "receiver");
			for (int k = 0; k < 12; k++) begin
				ch1 = (k == 0) ? 8'h80 : 8'($random(seed));
				ch2 = (k == 0) ? 8'h00 : 8'($random(seed));
				tick(3);
				sum = {1'b0, pe[0] ? ch1 : 8'h00} + {1'b0, pe[1] ? ch2 : 8'h00};
				check_bit(data_pin_out & data_pin_oe, (sum > 9'h080) ^ e ^ inv, "rx data");
			end
		end
		// receiver is on before recovered data is selected
		wr(8'h1d, 8'h01);
		check_role(rfdp_pkg::ROLE_CDR_OUT);
		repeat (8) begin
			cdr_data = 1'($random(seed));
			tick(3);
			check_bit(data_pin_out & data_pin_oe, cdr_data ^ 1'b1, "recovered");
		end
		tick(20);
		check_byte(8'(exp_q.size()), 8'h00, "reads pending");
		check_bit(sda_out, 1'b0, "bus line only pulled low");
		complete_run();
	end
endmodule : testbench
